/* File: src/ast_pkg.sv */
package ast_pkg;
   // register indices (no offsets printed; byte address = index * 4)
   localparam logic [3:0] IDX_INTCTL  = 4'h0;  // interrupt_global_control
   localparam logic [3:0] IDX_PERIPHERAL_INTERRUPT_ENABLE_ONE    = 4'h1;  // peripheral_interrupt_enable_one
   localparam logic [3:0] IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE    = 4'h2;  // peripheral_interrupt_flags_one
   localparam logic [3:0] IDX_RECEIVE_STATUS_CONTROL   = 4'h3;  // receive_status_control
   localparam logic [3:0] IDX_BAUD    = 4'h4;  // baud_divisor
   localparam logic [3:0] IDX_PORT_C_DIRECTION   = 4'h5;  // port_c_direction
   localparam logic [3:0] IDX_TXHOLD  = 4'h6;  // transmit_holding_data
   localparam logic [3:0] IDX_TRANSMIT_STATUS_CONTROL   = 4'h7;  // transmit_status_control
   // field positions
   localparam int GIE_BIT   = 7;
   localparam int PERIPHERAL_INTERRUPT_ENABLE_BIT  = 6;
   localparam int TRANSMIT_INTERRUPT_ENABLE_BIT  = 4;
   localparam int TRANSMIT_BUFFER_EMPTY_FLAG_BIT  = 4;
   localparam int SERIAL_PORT_ENABLE_BIT  = 7;
   localparam int CLOCK_SOURCE_SELECT_BIT  = 7;
   localparam int TX9_BIT   = 6;
   localparam int TRANSMIT_ENABLE_BIT_BIT  = 5;
   localparam int SYNC_BIT  = 4;
   localparam int HIGH_SPEED_BAUD_SELECT_BIT  = 2;
   localparam int SHIFT_REGISTER_EMPTY_STATUS_BIT  = 1;
   localparam int NINTH_TRANSMIT_DATA_BIT_BIT  = 0;
   localparam int TXPIN_BIT = 6;  // port c bit of transmit_clock_pin
   localparam int RXPIN_BIT = 7;  // port c bit of receive_data_pin
   // reset values
   localparam logic [7:0] RST_ZERO  = 8'h00;
   localparam logic [7:0] RST_PORT_C_DIRECTION = 8'hff;
   localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
   localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WMASK = 8'hf5;  // writable control bits
   // baud: bit period = (divisor + 1) * prescale system clocks
   localparam logic [5:0] PRE_LOW   = 6'h3f;  // slow select: 64 clocks per step
   localparam logic [5:0] PRE_HIGH  = 6'h0f;  // fast select: 16 clocks per step
   localparam logic [3:0] BITS_8    = 4'h9;   // start + 8 data
   localparam logic [3:0] BITS_9    = 4'ha;   // start + 9 data
   // register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ast_bus_s;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_STOP} ast_state_e;
endpackage

/* File: src/ast_transmitter.sv */
// Overview of operation
// - idle mark, start space, data, stop mark
// - data sent least significant bit first
// - bit period from eight bit divider
// - no hardware parity, ninth bit carries it
// - active only enabled, asynchronous, port enabled
// - port enable makes transmit pin output
// - port enable forces receive pin input
// - empty flag sets when transmit enabled
// - holding write starts transmission, loads if idle
// - queued char loads within cycle after stop
// - start bit begins right after loading
// - empty flag clear only busy and queued; here also clear whenever transmitter not active (reset, disabled, sync)
// - empty flag valid second cycle after write
// - empty flag read only to software
// - empty flag ignores interrupt enable
// - shift empty status, no interrupt
// - nine bit mode, ninth bit is msb
// - interrupt raised when all enables set
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter #(
   parameter int DIV_W = 8   // baud divider width
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              arst_n,
   // register port
   input  wire ast_pkg::ast_bus_s busReq,
   output var  logic [7:0]        rdData,
   // pins (port c bits 6 and 7)
   input  wire logic              txPinIn,
   output var  logic              txPinOut,
   output var  logic              txPinOe,
   input  wire logic              rxPinIn,
   output var  logic              rxPinOut,
   output var  logic              rxPinOe,
   // port logic latch for the two pins
   input  wire logic [1:0]        portLatch,
   // interrupt request to the core
   output var  logic              irqOut
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0]             intctl_reg;     // interrupt enables
   logic [7:0]             pie_reg;        // peripheral enables
   logic [7:0]             receive_status_control_reg;      // port enable lives here
   logic [DIV_W-1:0]       baud_reg;       // baud divisor value
   logic [7:0]             port_c_direction_reg;      // pin direction bits
   logic [7:0]             hold_reg;       // transmit holding register
   logic                   holdFull_reg;   // holding register occupied
   logic [7:0]             transmit_status_control_reg;      // control bits (status derived)
   logic [8:0]             shift_reg;      // transmit shift register
   logic [3:0]             bitCnt_reg;     // bits left in frame
   logic [5:0]             pre_reg;        // prescale counter
   logic [DIV_W-1:0]       div_reg;        // divisor counter
   logic                   line_reg;       // serial line level
   logic                   transmit_buffer_empty_flag_reg;       // buffer empty flag
   ast_pkg::ast_state_e    state_reg;      // shifter state
   logic                   txActive;       // transmitter enabled
   logic                   tick;           // one bit period elapsed
   logic                   wrHold;         // holding register write
   logic                   loadNow;        // move holding to shifter
   logic                   serial_port_enable;           // serial port enable
   logic [7:0]             rdNext;         // read mux

   assign serial_port_enable = receive_status_control_reg[ast_pkg::SERIAL_PORT_ENABLE_BIT];
   assign txActive = transmit_status_control_reg[ast_pkg::TRANSMIT_ENABLE_BIT_BIT] & ~transmit_status_control_reg[ast_pkg::SYNC_BIT]
                     & serial_port_enable;
   assign wrHold = busReq.wr && busReq.addr == ast_pkg::IDX_TXHOLD;
   // loads when shifter idle and a char is waiting
   assign loadNow = txActive && holdFull_reg && state_reg == ast_pkg::ST_IDLE;

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // plain control registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         intctl_reg <= ast_pkg::RST_ZERO;
         pie_reg    <= ast_pkg::RST_ZERO;
         receive_status_control_reg  <= ast_pkg::RST_ZERO;
         baud_reg   <= '0;
         port_c_direction_reg  <= ast_pkg::RST_PORT_C_DIRECTION;
         transmit_status_control_reg  <= ast_pkg::RST_TRANSMIT_STATUS_CONTROL;
      end else if (busReq.wr) begin
         case (busReq.addr)
            ast_pkg::IDX_INTCTL: intctl_reg <= busReq.wdata;
            ast_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLE_ONE:   pie_reg    <= busReq.wdata;
            ast_pkg::IDX_RECEIVE_STATUS_CONTROL:  receive_status_control_reg  <= busReq.wdata;
            ast_pkg::IDX_BAUD:   baud_reg   <= busReq.wdata[DIV_W-1:0];
            ast_pkg::IDX_PORT_C_DIRECTION:  port_c_direction_reg  <= busReq.wdata;
            // status bit not writable
            ast_pkg::IDX_TRANSMIT_STATUS_CONTROL:  transmit_status_control_reg  <= busReq.wdata & ast_pkg::TRANSMIT_STATUS_CONTROL_WMASK;
            default: ;
         endcase
      end
   end

   // holding register; ninth bit copied at load time
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hold_reg     <= ast_pkg::RST_ZERO;
         holdFull_reg <= 1'b0;
      end else begin
         if (wrHold) begin
            hold_reg     <= busReq.wdata;
            holdFull_reg <= 1'b1;
         end else if (loadNow || !txActive) begin
            holdFull_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // baud generator
   // ----------------------------------------------------------------
   // prescale then divisor count; restarts at each load
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pre_reg <= '0;
         div_reg <= '0;
      end else if (loadNow || state_reg == ast_pkg::ST_IDLE) begin
         pre_reg <= '0;
         div_reg <= '0;
      end else if (pre_reg == (transmit_status_control_reg[ast_pkg::HIGH_SPEED_BAUD_SELECT_BIT] ? ast_pkg::PRE_HIGH
                                                             : ast_pkg::PRE_LOW)) begin
         pre_reg <= '0;
         div_reg <= tick ? '0 : div_reg + 1'b1;
      end else begin
         pre_reg <= pre_reg + 1'b1;
      end
   end
   assign tick = (pre_reg == (transmit_status_control_reg[ast_pkg::HIGH_SPEED_BAUD_SELECT_BIT] ? ast_pkg::PRE_HIGH
                                                            : ast_pkg::PRE_LOW))
                 && div_reg == baud_reg;

   // ----------------------------------------------------------------
   // shifter
   // ----------------------------------------------------------------
   // frame: start, data lsb first, stop
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg  <= ast_pkg::ST_IDLE;
         shift_reg  <= '0;
         bitCnt_reg <= '0;
         line_reg   <= 1'b1;
      end else if (!txActive) begin
         state_reg <= ast_pkg::ST_IDLE;
         line_reg  <= 1'b1;
      end else begin
         case (state_reg)
            ast_pkg::ST_IDLE: begin
               line_reg <= 1'b1;  // idle mark
               if (loadNow) begin
                  // ninth bit as msb; parity only via software
                  shift_reg  <= {transmit_status_control_reg[ast_pkg::NINTH_TRANSMIT_DATA_BIT_BIT], hold_reg};
                  bitCnt_reg <= transmit_status_control_reg[ast_pkg::TX9_BIT] ? ast_pkg::BITS_9
                                                            : ast_pkg::BITS_8;
                  line_reg   <= 1'b0;  // start bit at once
                  state_reg  <= ast_pkg::ST_SHIFT;
               end
            end
            ast_pkg::ST_SHIFT: begin
               if (tick) begin
                  bitCnt_reg <= bitCnt_reg - 1'b1;
                  if (bitCnt_reg == 4'h1) begin
                     line_reg  <= 1'b1;  // stop mark
                     state_reg <= ast_pkg::ST_STOP;
                  end else begin
                     line_reg  <= shift_reg[0];
                     shift_reg <= {1'b0, shift_reg[8:1]};
                  end
               end
            end
            ast_pkg::ST_STOP: begin
               if (tick) begin
                  state_reg <= ast_pkg::ST_IDLE;  // next load next cycle
               end
            end
            default: state_reg <= ast_pkg::ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // flags, pins, read data
   // ----------------------------------------------------------------
   // empty flag registered: the write cycle still reads old value
   // a char written into an idle shifter moves on at once, so the flag
   // must stay set then; while active it drops only when a char waits behind a busy
   // shifter, otherwise software would see a false full buffer
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         transmit_buffer_empty_flag_reg <= 1'b0;
      end else begin
         transmit_buffer_empty_flag_reg <= txActive & ~(holdFull_reg & (state_reg != ast_pkg::ST_IDLE));
      end
   end

   // pin direction and drive
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         txPinOut <= 1'b0;
         txPinOe  <= 1'b0;
         rxPinOut <= 1'b0;
         rxPinOe  <= 1'b0;
         irqOut   <= 1'b0;
      end else begin
         txPinOut <= serial_port_enable ? (txActive ? line_reg : 1'b1) : portLatch[0];
         txPinOe  <= serial_port_enable | ~port_c_direction_reg[ast_pkg::TXPIN_BIT];
         rxPinOut <= portLatch[1];
         rxPinOe  <= ~serial_port_enable & ~port_c_direction_reg[ast_pkg::RXPIN_BIT];
         // shift empty status raises nothing gated by enables
         irqOut   <= transmit_buffer_empty_flag_reg & pie_reg[ast_pkg::TRANSMIT_INTERRUPT_ENABLE_BIT]
                     & intctl_reg[ast_pkg::GIE_BIT] & intctl_reg[ast_pkg::PERIPHERAL_INTERRUPT_ENABLE_BIT];
      end
   end

   // read mux; flag and shift status are read only
   always_comb begin
      rdNext = ast_pkg::RST_ZERO;
      case (busReq.addr)
         ast_pkg::IDX_INTCTL: rdNext = intctl_reg;
         ast_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLE_ONE:   rdNext = pie_reg;
         ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE:   rdNext = {3'h0, transmit_buffer_empty_flag_reg, 4'h0};
         ast_pkg::IDX_RECEIVE_STATUS_CONTROL:  rdNext = receive_status_control_reg;
         ast_pkg::IDX_BAUD:   rdNext = 8'(baud_reg);
         ast_pkg::IDX_PORT_C_DIRECTION:  rdNext = port_c_direction_reg;
         ast_pkg::IDX_TRANSMIT_STATUS_CONTROL: begin
            rdNext = transmit_status_control_reg;
            rdNext[ast_pkg::SHIFT_REGISTER_EMPTY_STATUS_BIT] = state_reg == ast_pkg::ST_IDLE && !loadNow;
         end
         ast_pkg::IDX_TXHOLD: rdNext = ast_pkg::RST_ZERO;  // write only
         default:             rdNext = ast_pkg::RST_ZERO;
      endcase
   end

   // read data one cycle after strobe, port pins not readable
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdData <= ast_pkg::RST_ZERO;
      end else if (busReq.rd) begin
         rdData <= rdNext;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   idle_mark_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (state_reg == ast_pkg::ST_IDLE && !$past(loadNow)) |-> line_reg)
      else $error("line not mark while idle");
   start_space_a: assert property (@(posedge mclk) disable iff (!arst_n)
      loadNow |=> !line_reg && state_reg == ast_pkg::ST_SHIFT)
      else $error("start bit not sent after load");
   stop_mark_a: assert property (@(posedge mclk) disable iff (!arst_n)
      state_reg == ast_pkg::ST_STOP |-> line_reg)
      else $error("stop bit not mark");
   enable_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
      !txActive |=> state_reg == ast_pkg::ST_IDLE)
      else $error("shifter runs while disabled");
   flag_lag_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (wrHold && transmit_buffer_empty_flag_reg && txActive && state_reg == ast_pkg::ST_SHIFT)
      |=> transmit_buffer_empty_flag_reg ##1 !transmit_buffer_empty_flag_reg)
      else $error("empty flag timing wrong");
   flag_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(txActive) |=> ##1 transmit_buffer_empty_flag_reg || holdFull_reg)
      else $error("empty flag not set on enable");
   tx_pin_a: assert property (@(posedge mclk) disable iff (!arst_n)
      serial_port_enable |=> txPinOe)
      else $error("transmit pin not output");
   rx_pin_a: assert property (@(posedge mclk) disable iff (!arst_n)
      serial_port_enable |=> !rxPinOe)
      else $error("receive pin driven");
   queued_load_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (state_reg == ast_pkg::ST_STOP && tick && holdFull_reg && txActive) |=> ##1
      state_reg == ast_pkg::ST_SHIFT)
      else $error("queued char not loaded");
   irq_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
      irqOut |-> $past(pie_reg[ast_pkg::TRANSMIT_INTERRUPT_ENABLE_BIT]) && $past(transmit_buffer_empty_flag_reg))
      else $error("interrupt without enable");

   // ----------------------------------------------------------------
   // assertions on flag, bit order, queue and interrupt
   // ----------------------------------------------------------------
   // while active, flag low only behind a busy shifter with a queued char
   flag_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (!transmit_buffer_empty_flag_reg && $past(txActive))
      |-> $past(holdFull_reg && state_reg != ast_pkg::ST_IDLE))
      else $error("empty flag clear without queued char");

   // each data tick puts the next low bit on the line
   lsb_first_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (state_reg == ast_pkg::ST_SHIFT && tick && bitCnt_reg != 4'h1 && txActive)
      |=> line_reg == $past(shift_reg[0]))
      else $error("data bit out of order");

   // nine bit mode loads the longer frame count
   nine_len_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (loadNow && transmit_status_control_reg[ast_pkg::TX9_BIT]) |=> bitCnt_reg == ast_pkg::BITS_9)
      else $error("nine bit frame length wrong");

   // all enables and a set flag raise the request next cycle
   irq_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (transmit_buffer_empty_flag_reg && pie_reg[ast_pkg::TRANSMIT_INTERRUPT_ENABLE_BIT] && intctl_reg[ast_pkg::GIE_BIT]
       && intctl_reg[ast_pkg::PERIPHERAL_INTERRUPT_ENABLE_BIT]) |=> irqOut)
      else $error("interrupt not raised");

   // a queued char is kept while the shifter is still busy
   queue_keep_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (holdFull_reg && state_reg != ast_pkg::ST_IDLE && txActive) |=> holdFull_reg)
      else $error("queued char lost");

   // port enabled but transmitter off: pin shows mark
   tx_idle_a: assert property (@(posedge mclk) disable iff (!arst_n)
      (serial_port_enable && !txActive) |=> txPinOut)
      else $error("idle pin not mark");

   frame_c: cover property (@(posedge mclk) disable iff (!arst_n)
      state_reg == ast_pkg::ST_STOP ##1 state_reg == ast_pkg::ST_IDLE);
   nine_c: cover property (@(posedge mclk) disable iff (!arst_n)
      loadNow && transmit_status_control_reg[ast_pkg::TX9_BIT]);
   b2b_c: cover property (@(posedge mclk) disable iff (!arst_n)
      state_reg == ast_pkg::ST_STOP && holdFull_reg);
   irq_c: cover property (@(posedge mclk) disable iff (!arst_n) $rose(irqOut));
   // frame cut by turning the transmitter off
   abort_c: cover property (@(posedge mclk) disable iff (!arst_n)
      $fell(txActive) && state_reg != ast_pkg::ST_IDLE);
endmodule
`default_nettype wire

/* File: sim/ast_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// remote receiver sampling the line
// ----------------------------------------
module ast_rx_model (
   // clock and line
   input  wire logic       mclk,
   input  wire logic       line,
   // format the far end expects
   input  wire logic       nine,
   input  var  int         bitClks,
   // decoded result
   output var  logic [8:0] rxData,
   output var  int         rxCount,
   output var  int         rxGap,
   output var  logic       frameErr
);
   int n;  // idle cycles before a start edge

   // frame decoder: mid-bit sampling, like a real receiver
   initial begin
      rxData = 9'h000;
      rxCount = 0;
      rxGap = 0;
      frameErr = 1'b0;
      forever begin
         n = 0;
         while (line !== 1'b0) begin  // idle is mark
            @(posedge mclk);
            n++;
         end
         rxGap = n;
         repeat (bitClks / 2) @(posedge mclk);
         if (line !== 1'b0) frameErr = 1'b1;  // start must be space
         rxData = 9'h000;
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bitClks) @(posedge mclk);
            rxData[i] = line;  // lsb first, ninth bit on top
         end
         repeat (bitClks) @(posedge mclk);
         if (line !== 1'b1) frameErr = 1'b1;  // stop must be mark
         rxCount++;
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic              mclk;
   logic              arst_n;
   ast_pkg::ast_bus_s busReq;
   logic [7:0]        rdData;
   logic              txPinOut;
   logic              txPinOe;
   logic              rxPinOut;
   logic              rxPinOe;
   logic              irqOut;
   logic [1:0]        portLatch;
   logic              lineLvl;    // resolved tx wire, pulled up
   logic              nine;
   int                bitClks;
   int                rxCount;
   int                rxGap;
   int                err_count;
   int                checked;
   logic [8:0]        rxData;
   logic              frameErr;
   logic [7:0]        rv;

   assign lineLvl = txPinOe ? txPinOut : 1'b1;

   // ----------------------------------------
   // design and far-end receiver
   // ----------------------------------------
   ast_transmitter ast_transmitter_inst (
      .mclk(mclk), .arst_n(arst_n), .busReq(busReq), .rdData(rdData),
      .txPinIn(lineLvl), .txPinOut(txPinOut), .txPinOe(txPinOe),
      .rxPinIn(1'b1), .rxPinOut(rxPinOut), .rxPinOe(rxPinOe),
      .portLatch(portLatch), .irqOut(irqOut));
   ast_rx_model ast_rx_model_inst (
      .mclk(mclk), .line(lineLvl), .nine(nine), .bitClks(bitClks),
      .rxData(rxData), .rxCount(rxCount), .rxGap(rxGap), .frameErr(frameErr));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      busReq <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      busReq <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      rd(a, rv);
      chk({1'b0, rv}, {1'b0, exp});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic waitCount(input int n);
      for (int i = 0; i < 4000 && rxCount < n; i++) @(posedge mclk);
      chk(rxCount[8:0], n[8:0]);
      chk({8'h00, frameErr}, 9'h000);
   endtask
   task automatic final_report;
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // watchdog against a hung transfer
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      final_report();
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      busReq = '0;
      portLatch = 2'b10;
      nine = 1'b0;
      bitClks = 16;
      err_count = 0;
      checked = 0;
      arst_n = 1'b0;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      // reset values, index 8 unmapped
      for (int i = 0; i < 9; i++) begin
         rchk(i[3:0], (i == 5) ? 8'hff : (i == 7) ? 8'h02 : 8'h00);
      end
      // port logic: tx pin input, rx pin driven high
      wr(ast_pkg::IDX_PORT_C_DIRECTION, 8'h40);
      idle(3);
      chk({6'h00, txPinOe, rxPinOe, rxPinOut}, 9'h003);
      wr(ast_pkg::IDX_BAUD, 8'h00);
      wr(ast_pkg::IDX_RECEIVE_STATUS_CONTROL, 8'h80);
      idle(3);
      chk({6'h00, txPinOe, txPinOut, rxPinOe}, 9'h006);
      rchk(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h00);
      // enable, fast select; bit 3 and status bit not writable
      wr(ast_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h2c);
      rchk(ast_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h26);
      rchk(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h10);
      wr(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h00);
      rchk(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h10);
      // back-to-back characters
      wr(ast_pkg::IDX_TXHOLD, 8'ha5);
      wr(ast_pkg::IDX_TXHOLD, 8'h3c);
      rchk(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h00);
      rchk(ast_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h24);
      waitCount(1);
      chk(rxData, 9'h0a5);
      waitCount(2);
      chk(rxData, 9'h03c);
      chk({8'h00, rxGap >= 7 && rxGap <= 12}, 9'h001);
      idle(20);
      rchk(ast_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h26);
      rchk(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h10);
      // interrupt gating
      wr(ast_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLE_ONE, 8'h10);
      idle(3);
      chk({8'h00, irqOut}, 9'h000);
      wr(ast_pkg::IDX_INTCTL, 8'hc0);
      idle(3);
      chk({8'h00, irqOut}, 9'h001);
      wr(ast_pkg::IDX_INTCTL, 8'h80);
      idle(3);
      chk({8'h00, irqOut}, 9'h000);
      wr(ast_pkg::IDX_PERIPHERAL_INTERRUPT_ENABLE_ONE, 8'h00);
      rchk(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h10);
      // nine bits, slow select, divisor 1: 128 clocks a bit
      wr(ast_pkg::IDX_BAUD, 8'h01);
      bitClks = 128;
      nine = 1'b1;
      wr(ast_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h61);
      wr(ast_pkg::IDX_TXHOLD, 8'h5a);
      waitCount(3);
      chk(rxData, 9'h15a);
      // synchronous select blocks the asynchronous transmitter
      bitClks = 16;
      nine = 1'b0;
      wr(ast_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h34);
      wr(ast_pkg::IDX_TXHOLD, 8'hff);
      idle(400);
      chk(rxCount[8:0], 9'h003);
      wr(ast_pkg::IDX_TRANSMIT_STATUS_CONTROL, 8'h04);
      rchk(ast_pkg::IDX_PERIPHERAL_INTERRUPT_FLAGS_ONE, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
